// *** logic/mpio_pkg.sv ***
package mpio_pkg;
    localparam logic [7:0] MPIO_OFS_B_DATA = 8'h00;
    localparam logic [7:0] MPIO_OFS_B_DIR = 8'h04;
    localparam logic [7:0] MPIO_OFS_C_DATA = 8'h08;
    localparam logic [7:0] MPIO_OFS_C_DIR = 8'h0C;
    localparam logic [7:0] MPIO_OFS_C_FUNC = 8'h10;
    localparam logic [7:0] MPIO_OFS_D_DATA = 8'h14;
    localparam logic [7:0] MPIO_OFS_F_DATA = 8'h18;
    localparam logic [7:0] MPIO_OFS_F_DIR = 8'h1C;
    localparam logic [7:0] MPIO_OFS_MMAP = 8'h20;
    localparam logic [7:0] MPIO_OFS_B_SET = 8'h24;
    localparam logic [7:0] MPIO_OFS_B_CLR = 8'h28;
    localparam logic [7:0] MPIO_OFS_STAT = 8'h2C;
    localparam logic [7:0] MPIO_DIR_RESET = 8'hFF;
    localparam logic [7:0] MPIO_FUNC_RESET = 8'h00;
    localparam logic [7:0] MPIO_LATCH_RESET = 8'h00;
    localparam logic [2:0] MPIO_MMAP_RESET = 3'h0;
    localparam int MPIO_MM_DIR_BIT = 0;
    localparam int MPIO_MM_SIZE_LO = 1;
    localparam int MPIO_MM_SIZE_HI = 2;
    localparam int MPIO_IRQ2_PIN = 3;
    localparam logic [1:0] MPIO_SIZE_256 = 2'h0;
    localparam logic [1:0] MPIO_SIZE_4K = 2'h1;
    localparam logic [1:0] MPIO_SIZE_16K = 2'h2;
    localparam logic [1:0] MPIO_SIZE_BIG = 2'h3;
    localparam logic [7:0] MPIO_F_MASK_4K = 8'h0F;
    localparam logic [7:0] MPIO_F_MASK_16K = 8'h3F;
    localparam logic [7:0] MPIO_F_MASK_BIG = 8'hFF;
    localparam logic [7:0] MPIO_F_MASK_NONE = 8'h00;
    typedef enum logic [1:0] {
        MPIO_CYC_ADDR = 2'b00,
        MPIO_CYC_DATA = 2'b01,
        MPIO_CYC_IDLE = 2'b10
    } mpio_cyc_t;
endpackage : mpio_pkg

// *** logic/mpio_pin_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// one 8-bit port: latch, enable and sampled pin level
interface mpio_pin_if;
    logic [7:0] pin_sync;
    logic [7:0] out_val;
    logic [7:0] out_en;
    modport core (input pin_sync, output out_val, output out_en);
    modport pad (output pin_sync, input out_val, input out_en);
endinterface : mpio_pin_if
`default_nettype wire

// *** logic/mpio_sync8.sv ***
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for one port's pin levels
module mpio_sync8 (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] pin_in,
    mpio_pin_if.pad port
);
    logic [7:0] meta_reg;
    logic [7:0] sync_reg;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= 8'h00;
            sync_reg <= 8'h00;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end
    assign port.pin_sync = sync_reg;
endmodule : mpio_sync8
`default_nettype wire

// *** logic/mpio_top.sv ***
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module mpio_top #(
    parameter bit HAS_D_PORT = 1'b1
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic hw_stop,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe,
    input wire logic [7:0] pc_in,
    output logic [7:0] pc_out,
    output logic [7:0] pc_oe,
    input wire logic [7:0] pd_in,
    output logic [7:0] pd_out,
    output logic [7:0] pd_oe,
    input wire logic [7:0] pf_in,
    output logic [7:0] pf_out,
    output logic [7:0] pf_oe,
    input wire logic [7:0] ctrl_out,
    input wire logic [7:0] ctrl_out_valid,
    output logic [7:0] ctrl_in,
    input wire logic [15:0] ext_addr,
    input wire logic addr_strobe,
    output logic ext_irq2_request_flag
);
    import mpio_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    mpio_pin_if b_if ();
    mpio_pin_if c_if ();
    mpio_pin_if d_if ();
    mpio_pin_if f_if ();
    mpio_sync8 u_sync_b (.ref_clk(ref_clk), .nrst(nrst), .pin_in(pb_in), .port(b_if.pad));
    mpio_sync8 u_sync_c (.ref_clk(ref_clk), .nrst(nrst), .pin_in(pc_in), .port(c_if.pad));
    mpio_sync8 u_sync_d (.ref_clk(ref_clk), .nrst(nrst), .pin_in(pd_in), .port(d_if.pad));
    mpio_sync8 u_sync_f (.ref_clk(ref_clk), .nrst(nrst), .pin_in(pf_in), .port(f_if.pad));

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] b_latch_reg;
    logic [7:0] port_b_direction_reg;
    logic [7:0] c_latch_reg;
    logic [7:0] port_c_direction_reg;
    logic [7:0] port_c_function_select_reg;
    logic [7:0] d_latch_reg;
    logic [7:0] f_latch_reg;
    logic [7:0] port_f_direction_reg;
    logic [2:0] memory_map_reg;
    logic irq2_reg;
    logic [7:0] wr_addr_reg;
    logic wr_pend_reg;
    logic [31:0] rdata_reg;
    mpio_cyc_t cyc_reg;

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    // writes commit in the data phase; reads are prepared from the
    // address so the answer is zero wait states
    wire addr_ok = hsel && hready && htrans[1];
    wire rd_take = addr_ok && !hwrite;
    wire wr_take = addr_ok && hwrite;
    wire [7:0] wr_data = hwdata[7:0];
    wire wr_b = wr_pend_reg && (wr_addr_reg == MPIO_OFS_B_DATA);
    wire wr_bdir = wr_pend_reg && (wr_addr_reg == MPIO_OFS_B_DIR);
    wire wr_bset = wr_pend_reg && (wr_addr_reg == MPIO_OFS_B_SET);
    wire wr_bclr = wr_pend_reg && (wr_addr_reg == MPIO_OFS_B_CLR);
    wire wr_c = wr_pend_reg && (wr_addr_reg == MPIO_OFS_C_DATA);
    wire wr_cdir = wr_pend_reg && (wr_addr_reg == MPIO_OFS_C_DIR);
    wire wr_cfn = wr_pend_reg && (wr_addr_reg == MPIO_OFS_C_FUNC);
    wire wr_d = wr_pend_reg && (wr_addr_reg == MPIO_OFS_D_DATA);
    wire wr_f = wr_pend_reg && (wr_addr_reg == MPIO_OFS_F_DATA);
    wire wr_fdir = wr_pend_reg && (wr_addr_reg == MPIO_OFS_F_DIR);
    wire wr_mm = wr_pend_reg && (wr_addr_reg == MPIO_OFS_MMAP);
    wire wr_stat = wr_pend_reg && (wr_addr_reg == MPIO_OFS_STAT);

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    wire [1:0] bus_size = {memory_map_reg[MPIO_MM_SIZE_HI], memory_map_reg[MPIO_MM_SIZE_LO]};
    wire d_expansion = (bus_size != MPIO_SIZE_256) || !HAS_D_PORT;
    wire d_dir_out = memory_map_reg[MPIO_MM_DIR_BIT];

    function automatic logic [7:0] f_addr_mask(input logic [1:0] sz);
        if (sz == MPIO_SIZE_4K) begin
            return MPIO_F_MASK_4K;
        end else if (sz == MPIO_SIZE_16K) begin
            return MPIO_F_MASK_16K;
        end else if (sz == MPIO_SIZE_BIG) begin
            return MPIO_F_MASK_BIG;
        end else begin
            return MPIO_F_MASK_NONE;
        end
    endfunction : f_addr_mask

    // port read: pins where input, latch where output
    function automatic logic [7:0] port_view(input logic [7:0] pins, input logic [7:0] latch,
                                             input logic [7:0] is_in);
        return (pins & is_in) | (latch & ~is_in);
    endfunction : port_view

    wire [7:0] f_addr = f_addr_mask(bus_size);
    wire [7:0] c_port_val = port_view(c_if.pin_sync, c_latch_reg, port_c_direction_reg);
    // control pins: pin level when dir 1, internal control signal when dir 0
    wire [7:0] c_ctrl_val = port_view(c_if.pin_sync, ctrl_out,
                                      port_c_direction_reg);
    wire [7:0] c_read = (c_ctrl_val & port_c_function_select_reg)
                      | (c_port_val & ~port_c_function_select_reg);
    wire [7:0] b_read = port_view(b_if.pin_sync, b_latch_reg, port_b_direction_reg);
    wire [7:0] d_read = port_view(d_if.pin_sync, d_latch_reg, {8{!d_dir_out}});
    wire [7:0] f_read = port_view(f_if.pin_sync, f_latch_reg, port_f_direction_reg);

    wire [7:0] rd_ofs = haddr[7:0];
    logic [7:0] rd_byte;
    always_comb begin
        if (rd_ofs == MPIO_OFS_B_DATA) begin
            rd_byte = b_read;
        end else if (rd_ofs == MPIO_OFS_B_DIR) begin
            rd_byte = port_b_direction_reg;
        end else if (rd_ofs == MPIO_OFS_C_DATA) begin
            rd_byte = c_read;
        end else if (rd_ofs == MPIO_OFS_C_DIR) begin
            rd_byte = port_c_direction_reg;
        end else if (rd_ofs == MPIO_OFS_C_FUNC) begin
            rd_byte = port_c_function_select_reg;
        end else if (rd_ofs == MPIO_OFS_D_DATA) begin
            rd_byte = d_read;
        end else if (rd_ofs == MPIO_OFS_F_DATA) begin
            rd_byte = f_read;
        end else if (rd_ofs == MPIO_OFS_F_DIR) begin
            rd_byte = port_f_direction_reg;
        end else if (rd_ofs == MPIO_OFS_MMAP) begin
            rd_byte = {5'h00, memory_map_reg};
        end else if (rd_ofs == MPIO_OFS_STAT) begin
            rd_byte = {6'h00, d_expansion, irq2_reg};
        end else begin
            rd_byte = 8'h00;
        end
    end

    // ----------------------------------------
    // latches and mode registers
    // ----------------------------------------
    // hardware stop acts like reset on the port b/c/f direction and port c function bits only
    wire b_set_any = wr_b || wr_bset || wr_bclr;
    wire [7:0] b_latch_next = wr_b ? wr_data :
                              wr_bset ? (b_latch_reg | wr_data) :
                              (b_latch_reg & ~wr_data);
    wire c_fn3_change = wr_cfn
        && (wr_data[MPIO_IRQ2_PIN] != port_c_function_select_reg[MPIO_IRQ2_PIN]);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            b_latch_reg <= MPIO_LATCH_RESET;
            c_latch_reg <= MPIO_LATCH_RESET;
            d_latch_reg <= MPIO_LATCH_RESET;
            f_latch_reg <= MPIO_LATCH_RESET;
            memory_map_reg <= MPIO_MMAP_RESET;
        end else begin
            if (b_set_any) b_latch_reg <= b_latch_next;
            if (wr_c) c_latch_reg <= wr_data;
            if (wr_d) d_latch_reg <= wr_data;
            if (wr_f) f_latch_reg <= wr_data;
            if (wr_mm) memory_map_reg <= wr_data[2:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_b_direction_reg <= MPIO_DIR_RESET;
            port_c_direction_reg <= MPIO_DIR_RESET;
            port_f_direction_reg <= MPIO_DIR_RESET;
            port_c_function_select_reg <= MPIO_FUNC_RESET;
        end else if (hw_stop) begin
            port_b_direction_reg <= MPIO_DIR_RESET;
            port_c_direction_reg <= MPIO_DIR_RESET;
            port_f_direction_reg <= MPIO_DIR_RESET;
            port_c_function_select_reg <= MPIO_FUNC_RESET;
        end else begin
            if (wr_bdir) port_b_direction_reg <= wr_data;
            if (wr_cdir) port_c_direction_reg <= wr_data;
            if (wr_fdir) port_f_direction_reg <= wr_data;
            if (wr_cfn) port_c_function_select_reg <= wr_data;
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq2_reg <= 1'b0;
        end else if (c_fn3_change) begin
            irq2_reg <= 1'b1;
        end else if (wr_stat && wr_data[0]) begin
            irq2_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= wr_take;
            if (wr_take) wr_addr_reg <= haddr[7:0];
            if (rd_take) rdata_reg <= {24'h000000, rd_byte};
        end
    end

    // ----------------------------------------
    // machine cycle tracking on the expansion bus
    // ----------------------------------------
    // address phase follows the strobe, data phase follows it and holds until the next strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cyc_reg <= MPIO_CYC_IDLE;
        end else if (addr_strobe) begin
            cyc_reg <= MPIO_CYC_ADDR;
        end else if (cyc_reg == MPIO_CYC_ADDR) begin
            cyc_reg <= MPIO_CYC_DATA;
        end else begin
            cyc_reg <= cyc_reg;
        end
    end

    // ----------------------------------------
    // pad drive
    // ----------------------------------------
    wire d_bus_addr = addr_strobe || (cyc_reg == MPIO_CYC_ADDR);
    wire [7:0] c_fn_oe = port_c_function_select_reg & ctrl_out_valid;
    wire [7:0] c_oe_n = c_fn_oe
                      | (~port_c_function_select_reg & ~port_c_direction_reg);
    wire [7:0] c_val_n = (ctrl_out & port_c_function_select_reg)
                       | (c_latch_reg & ~port_c_function_select_reg);
    wire [7:0] d_oe_n = d_expansion ? {8{d_bus_addr}} : {8{d_dir_out}};
    wire [7:0] d_val_n = d_expansion ? ext_addr[7:0] : d_latch_reg;
    wire [7:0] f_oe_n = f_addr | (~f_addr & ~port_f_direction_reg);
    wire [7:0] f_val_n = (ext_addr[15:8] & f_addr) | (f_latch_reg & ~f_addr);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pb_out <= 8'h00;
            pb_oe <= 8'h00;
            pc_out <= 8'h00;
            pc_oe <= 8'h00;
            pd_out <= 8'h00;
            pd_oe <= 8'h00;
            pf_out <= 8'h00;
            pf_oe <= 8'h00;
            ctrl_in <= 8'h00;
        end else begin
            pb_out <= b_latch_reg;
            pb_oe <= ~port_b_direction_reg;
            pc_out <= c_val_n;
            pc_oe <= c_oe_n;
            pd_out <= d_val_n;
            pd_oe <= d_oe_n;
            pf_out <= f_val_n;
            pf_oe <= f_oe_n;
            ctrl_in <= c_if.pin_sync;
        end
    end

    // interface out_val/out_en mirror the pads for the core modport
    assign b_if.out_val = pb_out;
    assign b_if.out_en = pb_oe;
    assign c_if.out_val = pc_out;
    assign c_if.out_en = pc_oe;
    assign d_if.out_val = pd_out;
    assign d_if.out_en = pd_oe;
    assign f_if.out_val = pf_out;
    assign f_if.out_en = pf_oe;

    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ext_irq2_request_flag = irq2_reg;
endmodule : mpio_top
`default_nettype wire

// *** tb/mpio_pads.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// external pads of ports b, c, d and f
// ----------------------------------------
module mpio_pads (
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    input wire logic [31:0] ext_lvl,
    output logic [31:0] pad_in
);
    // a released pin follows the outside level, never the stale latch value
    assign pad_in = (pad_out & pad_oe) | (ext_lvl & ~pad_oe);
endmodule : mpio_pads
`default_nettype wire

// *** tb/mpio_top_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module mpio_checker
    import mpio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic hw_stop,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [7:0] pb_oe,
    input wire logic [7:0] pc_oe,
    input wire logic [7:0] pd_out,
    input wire logic [7:0] pd_oe,
    input wire logic [7:0] pf_out,
    input wire logic [7:0] pf_oe,
    input wire logic [15:0] ext_addr,
    input wire logic addr_strobe,
    input wire logic ext_irq2_request_flag
);
    // ----------------------------------------
    // shadow of registers seen on bus writes
    // ----------------------------------------
    logic wr_reg;
    logic [7:0] wa_reg;
    logic [7:0] bdir_reg;
    logic [2:0] mm_reg;
    logic fn3_reg;
    wire logic fn_wr = wr_reg && (wa_reg == MPIO_OFS_C_FUNC);
    wire logic bdir_wr = wr_reg && (wa_reg == MPIO_OFS_B_DIR);
    wire logic [7:0] bdir_next = hw_stop ? MPIO_DIR_RESET : (bdir_wr ? hwdata[7:0] : bdir_reg);
    wire logic fn3_next = hw_stop ? 1'b0 : (fn_wr ? hwdata[3] : fn3_reg);
    wire logic mm_wr = wr_reg && (wa_reg == MPIO_OFS_MMAP);
    wire logic [2:0] mm_next = mm_wr ? hwdata[2:0] : mm_reg;
    wire logic expand = (mm_reg[2:1] != 2'h0);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_reg <= 1'b0;
            wa_reg <= 8'h00;
            bdir_reg <= MPIO_DIR_RESET;
            mm_reg <= MPIO_MMAP_RESET;
            fn3_reg <= 1'b0;
        end else begin
            wr_reg <= hsel && hready && htrans[1] && hwrite;
            wa_reg <= haddr[7:0];
            bdir_reg <= bdir_next;
            mm_reg <= mm_next;
            fn3_reg <= fn3_next;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    bus_okay_a: assert property (hreadyout == 1'b1 && hresp == 1'b0)
        else $error("bus slave stalled or answered with an error");
    b_dir_oe_a: assert property (pb_oe == ~$past(bdir_reg))
        else $error("port b enables do not follow the direction bits");
    stop_release_a: assert property (
        hw_stop [*3] |-> pb_oe == 8'h00 && pc_oe == 8'h00)
        else $error("port b or c still driving in hardware stop");
    d_port_dir_a: assert property (
        !expand |=> pd_oe == {8{$past(mm_reg[0])}})
        else $error("port d enable does not follow the byte direction bit");
    d_addr_out_a: assert property (
        expand && addr_strobe |=> pd_oe == 8'hFF && pd_out == $past(ext_addr[7:0]))
        else $error("port d does not carry the low address with the strobe");
    d_bus_idle_a: assert property (
        expand && !addr_strobe && !$past(addr_strobe) |=> pd_oe == 8'h00)
        else $error("port d bus driven outside the address slot");
    f_addr_4k_a: assert property (
        mm_reg[2:1] == 2'h1 |=> pf_oe[3:0] == 4'hF && pf_out[3:0] == $past(ext_addr[11:8]))
        else $error("port f low nibble does not carry high address in 4k mode");
    f_addr_16k_a: assert property (
        mm_reg[2:1] == 2'h2 |=> pf_oe[5:0] == 6'h3F && pf_out[5:0] == $past(ext_addr[13:8]))
        else $error("port f does not carry high address in 16k mode");
    f_addr_big_a: assert property (
        mm_reg[2:1] == 2'h3 |=> pf_oe == 8'hFF && pf_out == $past(ext_addr[15:8]))
        else $error("port f does not carry high address in large mode");
    irq2_set_a: assert property (
        fn_wr && !hw_stop && hwdata[3] != fn3_reg |-> ##[1:2] ext_irq2_request_flag)
        else $error("pin 3 function change did not raise the request flag");
endmodule : mpio_checker
bind mpio_top mpio_checker i_mpio_checker (
    .ref_clk(ref_clk), .nrst(nrst), .hw_stop(hw_stop), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .pb_oe(pb_oe), .pc_oe(pc_oe), .pd_out(pd_out),
    .pd_oe(pd_oe), .pf_out(pf_out), .pf_oe(pf_oe), .ext_addr(ext_addr),
    .addr_strobe(addr_strobe), .ext_irq2_request_flag(ext_irq2_request_flag)
);
`default_nettype wire

// *** tb/mpio_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module mpio_top_tb;
    import mpio_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic hw_stop = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq2;
    logic [7:0] pb_out, pb_oe, pc_out, pc_oe, pd_out, pd_oe, pf_out, pf_oe, ctrl_in;
    logic [7:0] ctrl_out = 8'h00;
    logic [7:0] ctrl_out_valid = 8'h00;
    logic [15:0] ext_addr = 16'hB7C3;
    logic addr_strobe = 1'b0;
    logic [31:0] ext_lvl = 32'h003C243C;
    logic [31:0] pad_in;
    logic [7:0] q, eoe;
    logic [7:0] ofs [5] = '{MPIO_OFS_B_DIR, MPIO_OFS_C_DIR, MPIO_OFS_C_FUNC, MPIO_OFS_F_DIR,
        MPIO_OFS_MMAP};
    logic [7:0] dflt [5] = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00};
    logic [7:0] fmask [3] = '{MPIO_F_MASK_4K, MPIO_F_MASK_16K, MPIO_F_MASK_BIG};
    int fails = 0;
    int compares = 0;
    wire logic hready = hreadyout;
    always #12.5 ref_clk = ~ref_clk;
    mpio_top #(.HAS_D_PORT(1'b1)) i_mpio_top (
        .ref_clk(ref_clk), .nrst(nrst), .hw_stop(hw_stop), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pb_in(pad_in[7:0]), .pb_out(pb_out), .pb_oe(pb_oe),
        .pc_in(pad_in[15:8]), .pc_out(pc_out), .pc_oe(pc_oe),
        .pd_in(pad_in[23:16]), .pd_out(pd_out), .pd_oe(pd_oe),
        .pf_in(pad_in[31:24]), .pf_out(pf_out), .pf_oe(pf_oe),
        .ctrl_out(ctrl_out), .ctrl_out_valid(ctrl_out_valid), .ctrl_in(ctrl_in),
        .ext_addr(ext_addr), .addr_strobe(addr_strobe), .ext_irq2_request_flag(irq2)
    );
    mpio_pads i_mpio_pads (.pad_out({pf_out, pd_out, pc_out, pb_out}),
        .pad_oe({pf_oe, pd_oe, pc_oe, pb_oe}), .ext_lvl(ext_lvl), .pad_in(pad_in));
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge ref_clk); while (hready !== 1'b1);
        q = hrdata[7:0];
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(nm, q, exp);
    endtask : rdchk
    // covers the two-flop pin synchroniser and the registered pads
    task automatic settle;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic defaults;
        for (int i = 0; i < 5; i++) rdchk("default", ofs[i], dflt[i]);
    endtask : defaults
    task automatic test_done;
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        defaults();
        chk("oe_reset", pb_oe | pc_oe | pd_oe | pf_oe, 8'h00);
        wr(MPIO_OFS_B_DATA, 8'hA5);
        wr(MPIO_OFS_B_DIR, 8'h0F);
        settle();
        chk("pb_oe", pb_oe, 8'hF0);
        chk("pb_out", pb_out & 8'hF0, 8'hA0);
        rdchk("pb_read", MPIO_OFS_B_DATA, 8'hAC);
        wr(MPIO_OFS_B_SET, 8'h02);
        wr(MPIO_OFS_B_CLR, 8'h80);
        wr(MPIO_OFS_B_DIR, 8'h00);
        settle();
        chk("pb_bits", pb_out, 8'h27);
        rdchk("pb_read_out", MPIO_OFS_B_DATA, 8'h27);
        ctrl_out <= 8'h80;
        ctrl_out_valid <= 8'h90;
        wr(MPIO_OFS_C_DATA, 8'hFF);
        wr(MPIO_OFS_C_DIR, 8'h7E);
        wr(MPIO_OFS_C_FUNC, 8'h94);
        settle();
        chk("pc_oe", pc_oe, 8'h91);
        chk("pc_out", pc_out & 8'h91, 8'h81);
        rdchk("pc_read", MPIO_OFS_C_DATA, 8'hA5);
        chk("ctrl_in", ctrl_in & 8'h04, 8'h04);
        rdchk("flag_idle", MPIO_OFS_STAT, 8'h00);
        wr(MPIO_OFS_C_FUNC, 8'h9C);
        rdchk("flag_set", MPIO_OFS_STAT, 8'h01);
        chk("flag_pin", {7'h00, irq2}, 8'h01);
        wr(MPIO_OFS_STAT, 8'h01);
        rdchk("flag_clear", MPIO_OFS_STAT, 8'h00);
        chk("flag_pin_clr", {7'h00, irq2}, 8'h00);
        @(posedge ref_clk);
        hw_stop <= 1'b1;
        repeat (3) @(posedge ref_clk);
        hw_stop <= 1'b0;
        settle();
        chk("oe_stop", pb_oe | pc_oe, 8'h00);
        defaults();
        wr(MPIO_OFS_STAT, 8'h01);
        wr(MPIO_OFS_D_DATA, 8'h5A);
        wr(MPIO_OFS_F_DATA, 8'hA5);
        wr(MPIO_OFS_F_DIR, 8'h3F);
        settle();
        chk("pd_oe_in", pd_oe, 8'h00);
        chk("pf_oe_port", pf_oe, 8'hC0);
        chk("pf_out_port", pf_out & 8'hC0, 8'h80);
        rdchk("pd_read", MPIO_OFS_D_DATA, 8'h3C);
        wr(MPIO_OFS_MMAP, 8'h01);
        settle();
        chk("pd_oe_out", pd_oe, 8'hFF);
        chk("pd_out", pd_out, 8'h5A);
        // reset clears the memory map and the latches, so expansion starts afresh
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        defaults();
        wr(MPIO_OFS_F_DATA, 8'hA5);
        wr(MPIO_OFS_F_DIR, 8'h3F);
        for (int i = 0; i < 3; i++) begin
            wr(MPIO_OFS_MMAP, {5'h00, 2'(i + 1), 1'b0});
            ext_addr <= ext_addr + 16'h1357;
            settle();
            eoe = fmask[i] | 8'hC0;
            chk("pf_oe_exp", pf_oe, eoe);
            chk("pf_out_exp", pf_out & eoe,
                ((ext_addr[15:8] & fmask[i]) | (8'hA5 & ~fmask[i])) & eoe);
            chk("pd_idle", pd_oe, 8'h00);
            rdchk("stat_exp", MPIO_OFS_STAT, 8'h02);
            @(posedge ref_clk);
            addr_strobe <= 1'b1;
            @(posedge ref_clk);
            addr_strobe <= 1'b0;
            #1;
            chk("pd_addr_oe", pd_oe, 8'hFF);
            chk("pd_addr", pd_out, ext_addr[7:0]);
        end
        wr(8'h40, 8'hFF);
        rdchk("unmapped", 8'h40, 8'h00);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        test_done();
    end
endmodule : mpio_top_tb
`default_nettype wire
